// ---- verilog/timer_pkg.sv ----
// Purpose: Shared constants and types for the prescaled down-counter timer
// Assumes: 32-bit APB, one word per register
// Notes:   Offsets are byte addresses
package timer_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_COUNT   = 8'h00;
  localparam logic [7:0] OFF_PRESC   = 8'h04;
  localparam logic [7:0] OFF_CTRL    = 8'h08;
  localparam logic [7:0] OFF_IRQ_ST  = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MSK = 8'h10;
  localparam logic [7:0] OFF_POWER   = 8'h14;

  // ---------------------------------------------------------------
  // Field positions of the control/status register
  // ---------------------------------------------------------------
  localparam int CTRL_TAP_LO  = 0;
  localparam int CTRL_TAP_HI  = 2;
  localparam int CTRL_RUN     = 3;
  localparam int CTRL_IRQ_EN  = 4;
  localparam int CTRL_EXT_SEL = 5;
  localparam int CTRL_ZERO    = 7;

  // Power register fields
  localparam int PWR_WAIT = 0;
  localparam int PWR_STOP = 1;

  // ---------------------------------------------------------------
  // Widths, divider and reset values
  // ---------------------------------------------------------------
  localparam int COUNT_W = 8;
  localparam int PRESC_W = 7;
  localparam int TAP_W   = 3;
  localparam int INT_DIV = 12;

  localparam logic [7:0] COUNT_RST = 8'hFF;
  localparam logic [6:0] PRESC_ALL = 7'h7F;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [1:0] IRQ_RST   = 2'h0;

  // Interrupt status bit positions
  localparam int EV_ZERO = 0;
  localparam int EV_WAKE = 1;

  // APB request carrier
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } apb_req_t;

  // Power modes
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_WAIT,
    MODE_STOP
  } power_mode_t;

endpackage

// ---- verilog/edge_tick.sv ----
// Purpose: Rising-edge detector producing a one-cycle tick
// Assumes: Input already synchronous to ref_clk
// Notes:   Tick only while enabled; history kept while frozen
`timescale 1ns/1ps
module edge_tick (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic level,
  output wire logic tick
);

  logic last_level;

  // ---------------------------------------------------------------
  // Edge history
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      last_level <= 1'b0;
    end else if (enable) begin
      last_level <= level;
    end
  end

  assign tick = enable & level & ~last_level;

endmodule

// ---- verilog/prescaled_down_counter_timer.sv ----
// Purpose: 8-bit down-counter behind a 7-bit prescaler, APB register access
// Assumes: ref_clk 25 MHz, timer_pin synchronous to ref_clk
// Notes:   Interrupt block beside the control/status zero flag
//
// Function
// - The count drops by one on each rising edge of the selected tap.
// - Software may write and read the count at any time; the code ignores count writes in STOP.
// - Reaching zero sets the zero-reached flag in the control register.
// - An interrupt is requested while the flag and its enable are set.
// - The timer interrupt ends WAIT mode.
// - The prescaler is fed by the clock divided by 12 or by the pin.
// - The prescaler drops by one on each rising edge of its input.
// - The tap select picks the prescaler input or prescaler bit n-1.
// - With run low all prescaler bits are ones and the count holds.
// - With run high software may load the prescaler from 0 to 7Fh; the code ignores prescaler writes in STOP.
// - The present prescaler state is readable.
// - In WAIT the clock keeps running and the timer keeps counting.
// - In STOP the timer freezes and keeps its register contents.
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module prescaled_down_counter_timer
  import timer_pkg::*;
#(
  parameter int DIVIDE = INT_DIV
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output wire logic        pready,
  output wire logic        pslverr,
  input  wire logic        timer_pin,
  input  wire logic        wake_event_in,
  output wire logic        timer_irq,
  output wire logic        irq,
  output wire logic        wake,
  output wire logic [1:0]  power_mode
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  apb_req_t             req;
  logic [COUNT_W-1:0]   count_value_reg;
  logic [PRESC_W-1:0]   prescaler_value_reg;
  logic [TAP_W-1:0]     tap_select;
  logic                 prescaler_run;
  logic                 zero_irq_enable;
  logic                 ext_clock_sel;
  logic                 zero_reached_flag;
  logic [1:0]           irq_status;
  logic [1:0]           irq_mask;
  power_mode_t          mode;
  power_mode_t          next_mode;
  logic [3:0]           div_cnt;
  logic                 div_out;
  logic                 clk_live;
  logic                 src_level;
  logic                 presc_tick;
  logic                 tap_level;
  logic                 tap_tick;
  logic                 count_tick;
  logic                 zero_event;
  logic                 wr;
  logic                 rd_en;
  logic                 mapped;
  logic                 wr_count;
  logic                 wr_presc;
  logic                 wr_ctrl;
  logic                 wr_ctrl_ok;
  logic                 wr_st;
  logic                 wr_msk;
  logic                 wr_pwr;
  logic [COUNT_W-1:0]   next_count;

  localparam logic [3:0] DIV_LAST = 4'(DIVIDE - 1);
  localparam logic [3:0] DIV_HALF = 4'(DIVIDE / 2);

  // Byte-lane qualified write of the low byte
  function automatic logic lane0(input logic [3:0] strb);
    lane0 = strb[0];
  endfunction

  // Address match for an access, used by the write decode and the error check
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  assign req = '{sel: psel, enable: penable, write: pwrite,
                 addr: paddr, wdata: pwdata};

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  assign pready  = 1'b1;
  assign mapped  = hit(req.addr, OFF_COUNT) | hit(req.addr, OFF_PRESC) |
                   hit(req.addr, OFF_CTRL) | hit(req.addr, OFF_IRQ_ST) |
                   hit(req.addr, OFF_IRQ_MSK) | hit(req.addr, OFF_POWER);
  assign pslverr = req.sel & req.enable & ~mapped;
  assign wr      = req.sel & req.enable & req.write & lane0(pstrb);
  // Read data is loaded in the setup cycle so it stands through access
  assign rd_en   = req.sel & ~req.enable & ~req.write;
  assign wr_count   = wr & hit(req.addr, OFF_COUNT);
  assign wr_presc   = wr & hit(req.addr, OFF_PRESC);
  assign wr_ctrl    = wr & hit(req.addr, OFF_CTRL);
  assign wr_st      = wr & hit(req.addr, OFF_IRQ_ST);
  assign wr_msk     = wr & hit(req.addr, OFF_IRQ_MSK);
  assign wr_pwr     = wr & hit(req.addr, OFF_POWER);
  assign wr_ctrl_ok = wr_ctrl;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (req.addr)
        OFF_COUNT:   prdata <= {24'h00_0000, count_value_reg};
        OFF_PRESC:   prdata <= {25'h000_0000, prescaler_value_reg};
        OFF_CTRL:    prdata <= {24'h00_0000, zero_reached_flag, 1'b0,
                                ext_clock_sel, zero_irq_enable,
                                prescaler_run, tap_select};
        OFF_IRQ_ST:  prdata <= {30'h0000_0000, irq_status};
        OFF_IRQ_MSK: prdata <= {30'h0000_0000, irq_mask};
        OFF_POWER:   prdata <= {30'h0000_0000, mode == MODE_STOP,
                                mode == MODE_WAIT};
        default:     prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Control bits
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      {zero_irq_enable, ext_clock_sel, prescaler_run, tap_select} <=
        {1'b0, 1'b0, 1'b0, 3'h0};
    end else if (wr_ctrl_ok && mode != MODE_STOP) begin
      tap_select      <= req.wdata[CTRL_TAP_HI:CTRL_TAP_LO];
      prescaler_run   <= req.wdata[CTRL_RUN];
      zero_irq_enable <= req.wdata[CTRL_IRQ_EN];
      ext_clock_sel   <= req.wdata[CTRL_EXT_SEL];
    end
  end

  // ---------------------------------------------------------------
  // Power mode
  // ---------------------------------------------------------------
  always_comb begin
    next_mode = mode;
    unique case (mode)
      MODE_RUN: begin
        if (wr_pwr && req.wdata[PWR_STOP]) begin
          next_mode = MODE_STOP;
        end else if (wr_pwr && req.wdata[PWR_WAIT]) begin
          next_mode = MODE_WAIT;
        end
      end
      MODE_WAIT: begin
        if (timer_irq || wake_event_in) begin
          next_mode = MODE_RUN;
        end
      end
      MODE_STOP: begin
        if (wake_event_in) begin
          next_mode = MODE_RUN;
        end
      end
      default: next_mode = MODE_RUN;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode <= MODE_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  assign power_mode = mode;
  assign wake       = (mode == MODE_WAIT) & timer_irq;
  // Clock gate: live in RUN and WAIT, frozen in STOP
  assign clk_live   = (mode != MODE_STOP);

  // ---------------------------------------------------------------
  // Internal divide-by-12 source
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      div_cnt <= 4'h0;
      div_out <= 1'b0;
    end else if (clk_live) begin
      div_cnt <= (div_cnt == DIV_LAST) ? 4'h0 : div_cnt + 4'h1;
      div_out <= (div_cnt == DIV_LAST) | (div_cnt < DIV_HALF - 4'h1);
    end
  end

  assign src_level = ext_clock_sel ? timer_pin : div_out;

  edge_tick src_edge (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .enable  (clk_live),
    .level   (src_level),
    .tick    (presc_tick)
  );

  // ---------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prescaler_value_reg <= PRESC_ALL;
    end else if (!prescaler_run) begin
      prescaler_value_reg <= PRESC_ALL;
    end else if (wr_presc && clk_live) begin
      prescaler_value_reg <= req.wdata[PRESC_W-1:0];
    end else if (presc_tick) begin
      prescaler_value_reg <= prescaler_value_reg - 7'h01;
    end
  end

  // Tap k: prescaler input for k=0, else bit k-1; the down-count makes
  // bit k-1 rise once every 2^k input edges
  always_comb begin
    tap_level = 1'b0;
    if (tap_select == 3'h0) begin
      tap_level = presc_tick;
    end else begin
      tap_level = prescaler_value_reg[tap_select - 3'h1];
    end
  end

  // ---------------------------------------------------------------
  // Counter clock tap
  // ---------------------------------------------------------------
  edge_tick tap_edge_det (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .enable  (clk_live),
    .level   (tap_level),
    .tick    (tap_tick)
  );

  // History runs while stopped, so setting run gives no false edge
  always_comb begin
    count_tick = 1'b0;
    if (prescaler_run && clk_live) begin
      if (tap_select == 3'h0) begin
        count_tick = presc_tick;
      end else begin
        count_tick = tap_tick;
      end
    end
  end

  // ---------------------------------------------------------------
  // Down-counter
  // ---------------------------------------------------------------
  localparam logic [COUNT_W-1:0] COUNT_ONE = COUNT_W'(1);

  // Next value of the down-count
  function automatic logic [COUNT_W-1:0] dec_count(
    input logic [COUNT_W-1:0] v
  );
    dec_count = v - COUNT_ONE;
  endfunction

  assign next_count = dec_count(count_value_reg);

  // A software load in the same cycle hides the tick
  assign zero_event = count_tick & ~wr_count &
                      (count_value_reg == COUNT_ONE);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count_value_reg <= COUNT_RST;
    end else if (wr_count && clk_live) begin
      count_value_reg <= req.wdata[COUNT_W-1:0];
    end else if (count_tick) begin
      count_value_reg <= next_count;
    end
  end

  // ---------------------------------------------------------------
  // Zero flag
  // ---------------------------------------------------------------
  // Set wins over a clearing write in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      zero_reached_flag <= 1'b0;
    end else if (zero_event) begin
      zero_reached_flag <= 1'b1;
    end else if (wr_ctrl_ok && clk_live && !req.wdata[CTRL_ZERO]) begin
      zero_reached_flag <= 1'b0;
    end
  end

  // Request follows the flag and its enable
  assign timer_irq = zero_reached_flag & zero_irq_enable;

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------
  logic [1:0] events;
  logic [1:0] st_clear;

  always_comb begin
    events          = 2'h0;
    events[EV_ZERO] = zero_event;
    events[EV_WAKE] = wake;
  end

  assign st_clear = wr_st ? req.wdata[1:0] : 2'h0;

  // Sticky bits, cleared by writing one; a new event wins
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_status <= IRQ_RST;
    end else begin
      irq_status <= (irq_status & ~st_clear) | events;
    end
  end

  // Mask bit high blocks the matching status bit
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_mask <= IRQ_RST;
    end else if (wr_msk) begin
      irq_mask <= req.wdata[1:0];
    end
  end

  // Level output while any unmasked status bit is set
  assign irq = |(irq_status & ~irq_mask);

endmodule

// ---- tb/timer_monitor.sv ----
// Purpose: Port checker for the down-counter timer
// Assumes: One clock, APB slave answering within a few cycles
// Notes:   Bound to every timer instance
`timescale 1ns/1ps
module timer_monitor
  import timer_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       timer_irq,
  input wire logic       wake,
  input wire logic [1:0] power_mode
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic       wr;
  logic [1:0] wr_d;
  assign wr = psel && penable && pwrite && pready;
  always_ff @(posedge ref_clk) wr_d <= {wr_d[0], wr};
  sequence woke;
    ##[0:3] (wake || power_mode == MODE_RUN);
  endsequence
  ready_bound_a:
    assert property (psel && penable |-> ##[0:8] pready) else $error("late");
  err_ready_a:
    assert property (pslverr |-> pready) else $error("stray error");
  flag_sticky_a:
    assert property (timer_irq && !wr && !wr_d[0] |=> timer_irq)
      else $error("flag lost");
  stop_freeze_a:
    assert property ($rose(timer_irq) && !(|wr_d) |->
      $past(power_mode) != MODE_STOP) else $error("count in stop");
  wake_exit_a:
    assert property ($rose(timer_irq) && power_mode == MODE_WAIT |-> woke)
      else $error("no wake");
  mode_hold_a:
    assert property (power_mode == MODE_RUN && !wr |=> power_mode == MODE_RUN)
      else $error("mode moved");
  mode_legal_a:
    assert property (power_mode inside {MODE_RUN, MODE_WAIT, MODE_STOP})
      else $error("bad mode");
  stop_stay_a:
    assert property (power_mode == MODE_STOP && !wr |=>
      power_mode != MODE_WAIT) else $error("stop to wait");
endmodule
bind prescaled_down_counter_timer timer_monitor mon (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .timer_irq(timer_irq), .wake(wake), .power_mode(power_mode));

// ---- tb/pin_source.sv ----
// Purpose: External clock source on the timer pin
// Assumes: Pulses synchronous to ref_clk
// Notes:   Pin rests low between bursts
`timescale 1ns/1ps
module pin_source #(
  parameter int PULSES = 20
) (
  input  wire logic ref_clk,
  input  wire logic go,
  output logic      pin,
  output logic      busy
);
  // ----------------------------------------
  // Burst of pulses, two cycles high, two low
  // ----------------------------------------
  logic [7:0] left  = 8'h00;
  logic [1:0] phase = 2'h0;
  always_ff @(posedge ref_clk) begin
    if (go) begin
      left  <= 8'(PULSES);
      phase <= 2'h0;
    end else if (left != 8'h00) begin
      phase <= phase + 2'h1;
      if (phase == 2'h3) begin
        left <= left - 8'h01;
      end
    end
  end
  assign pin  = (left != 8'h00) && !phase[1];
  assign busy = (left != 8'h00);
endmodule

// ---- tb/prescaled_down_counter_timer_bench.sv ----
// Purpose: Self-checking bench for the down-counter timer
// Assumes: Default internal divide of 12
// Notes:   Pin model supplies external edges
`timescale 1ns/1ps
module prescaled_down_counter_timer_bench;
  import timer_pkg::*;
  apb_req_t    req;
  logic        ref_clk, rst_n, go, pready, pslverr, timer_pin;
  logic        timer_irq, irq, wake, busy, wake_in;
  logic [1:0]  power_mode;
  logic [31:0] prdata, r;
  int          n_fail, tests_run;
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value at %0t: %h %h", $time, (a), (b)); end end
  prescaled_down_counter_timer dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(req.sel),
    .penable(req.enable), .pwrite(req.write), .paddr(req.addr),
    .pwdata(req.wdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_pin(timer_pin), .wake_event_in(wake_in),
    .timer_irq(timer_irq), .irq(irq), .wake(wake),
    .power_mode(power_mode));
  pin_source src (.ref_clk(ref_clk), .go(go), .pin(timer_pin), .busy(busy));
  // ----------------------------------------
  // Bus and helper tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{sel:1'b1, enable:1'b0, write:w, addr:a, wdata:d};
    @(posedge ref_clk);
    req.enable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 400 && timer_irq !== 1'b1; i++) @(posedge ref_clk);
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(OFF_COUNT);
    `CHK(r[7:0], COUNT_RST)
    rd(OFF_PRESC);
    `CHK(r[6:0], PRESC_ALL)
    rd(OFF_CTRL);
    `CHK(r[7:0], CTRL_RST)
    rd(8'h3C);
    wr(OFF_COUNT, 32'hA5);
    repeat (40) @(posedge ref_clk);
    rd(OFF_COUNT);
    `CHK(r[7:0], 8'hA5)
  endtask
  task automatic t_zero();
    wr(OFF_COUNT, 32'h3);
    wr(OFF_CTRL, 32'h18);
    wait_irq();
    rd(OFF_CTRL);
    `CHK(r[CTRL_ZERO], 1'b1)
    `CHK(timer_irq, 1'b1)
    rd(OFF_IRQ_ST);
    `CHK(r[EV_ZERO], 1'b1)
    `CHK(irq, 1'b1)
    wr(OFF_IRQ_MSK, 32'h1);
    `CHK(irq, 1'b0)
    wr(OFF_IRQ_MSK, 32'h0);
    wr(OFF_IRQ_ST, 32'h1);
    `CHK(irq, 1'b0)
    wr(OFF_CTRL, 32'h10);
    `CHK(timer_irq, 1'b0)
  endtask
  task automatic t_tap();
    for (int k = 0; k < 4; k++) begin
      wr(OFF_COUNT, 32'hFF);
      wr(OFF_CTRL, 32'h08 | k);
      repeat (96 << k) @(posedge ref_clk);
      rd(OFF_COUNT);
      `CHK((8'hFF - r[7:0]) inside {8'h7, 8'h8, 8'h9}, 1'b1)
      wr(OFF_CTRL, 32'h0);
    end
    wr(OFF_CTRL, 32'h0F);
    wr(OFF_PRESC, 32'h40);
    rd(OFF_PRESC);
    `CHK(r[6:0] inside {7'h40, 7'h3F}, 1'b1)
    wr(OFF_CTRL, 32'h0);
  endtask
  task automatic t_ext();
    wr(OFF_COUNT, 32'hFF);
    wr(OFF_CTRL, 32'h28);
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 200 && busy; i++) @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
    rd(OFF_COUNT);
    `CHK(r[7:0], 8'hEB)
    wr(OFF_CTRL, 32'h0);
  endtask
  task automatic t_power();
    logic [7:0] a;
    wr(OFF_COUNT, 32'hFF);
    wr(OFF_CTRL, 32'h08);
    wr(OFF_POWER, 32'h2);
    `CHK(power_mode, MODE_STOP)
    rd(OFF_COUNT);
    a = r[7:0];
    repeat (100) @(posedge ref_clk);
    rd(OFF_COUNT);
    `CHK(r[7:0], a)
    wake_in <= 1'b1;
    @(posedge ref_clk);
    wake_in <= 1'b0;
    @(posedge ref_clk);
    `CHK(power_mode, MODE_RUN)
    wr(OFF_COUNT, 32'h2);
    wr(OFF_CTRL, 32'h18);
    wr(OFF_POWER, 32'h1);
    `CHK(power_mode, MODE_WAIT)
    wait_irq();
    repeat (4) @(posedge ref_clk);
    `CHK(timer_irq, 1'b1)
    `CHK(power_mode, MODE_RUN)
    wr(OFF_CTRL, 32'h10);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    test_done();
  end
  initial begin
    rst_n = 1'b0;
    req = '0;
    go = 1'b0;
    wake_in = 1'b0;
    n_fail = 0;
    tests_run = 0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_zero();
    t_tap();
    t_ext();
    t_power();
    test_done();
  end
endmodule
